// ==== logic/ctx_scheduler.sv ====
// module: hardware context scheduler with master precedence and timer wake
`timescale 1ns/1ps

// Function
// - five contexts, numbered zero to four
// - master context ready always wins selection
// - protected settings written only by master
// - double faults routed to master context
// - claim semaphores only for contexts one-four
// - master trap instruction traps to master
// - equal priority ties go to lowest number
// - priority zero to seven, seven highest
// - five ticks: base, half, quarter, eighth, sixteenth
// - standard mode stacks, vectors, nests
// - fast vectored: vector, no stacking, no nesting
// - fast single-thread resumes at current counter
// - states halted, not ready, ready per context
// - wake tick only moves not ready to ready
module ctx_scheduler #(
  parameter int NUM_CTX = ctx_sched_pkg::NUM_CTX,
  parameter int NUM_TICK = ctx_sched_pkg::NUM_TICK
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire ctx_sched_pkg::ctx_wr_s ctx_wr_i,
  input wire ctx_sched_pkg::tmr_wr_s tmr_wr_i,
  input wire ctx_sched_pkg::tick_route_s [NUM_TICK-1:0] tick_route_i,
  input wire logic route_wr_i,
  input wire logic [ctx_sched_pkg::CTX_W-1:0] route_src_i,
  input wire ctx_sched_pkg::ctx_evt_s irq_i,
  input wire ctx_sched_pkg::ctx_evt_s fault_i,
  input wire ctx_sched_pkg::ctx_evt_s trap_i,
  input wire ctx_sched_pkg::ctx_evt_s irq_done_i,
  input wire ctx_sched_pkg::ctx_evt_s claim_set_i,
  input wire ctx_sched_pkg::ctx_evt_s claim_clr_i,
  output ctx_sched_pkg::sched_out_s sched_o,
  output logic [NUM_CTX-1:0] pending_o,
  output logic [NUM_CTX-1:0] claim_o,
  output logic [NUM_TICK-1:0] tick_o
);

  typedef struct packed {
    logic [NUM_CTX-1:0][1:0] state;
    logic [NUM_CTX-1:0][1:0] mode;
    logic [NUM_CTX-1:0][ctx_sched_pkg::PRIO_W-1:0] prio;
    logic [NUM_CTX-1:0] pend;
    logic [NUM_CTX-1:0] busy;
    logic [NUM_CTX-1:0] claim;
    logic tmr_en;
    logic [ctx_sched_pkg::RATE_W-1:0] rate_sel;
    logic [ctx_sched_pkg::PRESCALE_W-1:0] prescale;
    ctx_sched_pkg::tick_route_s [NUM_TICK-1:0] route;
    ctx_sched_pkg::sched_out_s sel;
    logic [NUM_TICK-1:0] tick;
  } sched_st_s;

  sched_st_s st_q;
  sched_st_s st_d;
  logic [NUM_TICK-1:0] tick_raw;
  logic [NUM_CTX-1:0] wake;
  logic [NUM_CTX-1:0] req;
  logic best_found;
  logic [ctx_sched_pkg::CTX_W-1:0] best_ctx;
  logic [ctx_sched_pkg::PRIO_W-1:0] best_prio;
  logic [NUM_CTX-1:0] cfg_hit;
  logic [NUM_CTX-1:0] rdy;
  logic tmr_hit;
  logic route_hit;

  // ----------------------------------------------------------------
  // system timer
  // ----------------------------------------------------------------
  sys_tick_gen #(
    .NUM_TICK(NUM_TICK),
    .PRESCALE_W(ctx_sched_pkg::PRESCALE_W)
  ) u_tick (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .enable_i(st_q.tmr_en),
    .rate_sel_i(st_q.rate_sel),
    .prescale_i(st_q.prescale),
    .tick_o(tick_raw)
  );

  // ----------------------------------------------------------------
  // event collection per context
  // ----------------------------------------------------------------
  always_comb
  begin
    wake = '0;
    req = '0;
    for (int t = 0; t < NUM_TICK; t++)
    begin
      if (tick_raw[t] && st_q.route[t].enable && int'(st_q.route[t].ctx) < NUM_CTX)
      begin
        if (st_q.route[t].wake_mode)
        begin
          wake[st_q.route[t].ctx] = 1'b1;
        end
        else
        begin
          req[st_q.route[t].ctx] = 1'b1;
        end
      end
    end
    if (irq_i.valid && int'(irq_i.ctx) < NUM_CTX)
    begin
      req[irq_i.ctx] = 1'b1;
    end
    // critical faults and the master trap land on context zero regardless of source
    if (fault_i.valid)
    begin
      req[ctx_sched_pkg::MASTER_CTX] = 1'b1;
    end
    if (trap_i.valid)
    begin
      req[ctx_sched_pkg::MASTER_CTX] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // master-only write decode and per-context readiness
  // ----------------------------------------------------------------
  always_comb
  begin
    // writes from any other context die here, so nothing below can see them
    tmr_hit = tmr_wr_i.valid && tmr_wr_i.src_ctx == ctx_sched_pkg::MASTER_CTX;
    route_hit = route_wr_i && route_src_i == ctx_sched_pkg::MASTER_CTX;
    cfg_hit = '0;
    rdy = '0;
    for (int c = 0; c < NUM_CTX; c++)
    begin
      if (ctx_wr_i.valid && ctx_wr_i.src_ctx == ctx_sched_pkg::MASTER_CTX && int'(ctx_wr_i.dst_ctx) == c)
      begin
        cfg_hit[c] = 1'b1;
      end
      // only a ready context may be picked; halted and not-ready never run
      rdy[c] = (st_q.state[c] == ctx_sched_pkg::ST_READY);
    end
  end

  // ----------------------------------------------------------------
  // selection: master first, then highest priority, lowest index on ties
  // ----------------------------------------------------------------
  always_comb
  begin
    best_found = 1'b0;
    best_ctx = ctx_sched_pkg::MASTER_CTX;
    best_prio = ctx_sched_pkg::PRIO_RESET;
    // walking downwards with >= lets the lower number win a tie
    for (int c = NUM_CTX - 1; c >= 0; c--)
    begin
      if (rdy[c] && (!best_found || st_q.prio[c] >= best_prio))
      begin
        best_found = 1'b1;
        best_ctx = c[ctx_sched_pkg::CTX_W-1:0];
        best_prio = st_q.prio[c];
      end
    end
    if (rdy[0])
    begin
      best_found = 1'b1;
      best_ctx = ctx_sched_pkg::MASTER_CTX;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.tick = tick_raw;
    if (tmr_hit)
    begin
      st_d.tmr_en = tmr_wr_i.enable;
      st_d.rate_sel = tmr_wr_i.rate_sel;
      st_d.prescale = tmr_wr_i.prescale;
    end
    if (route_hit)
    begin
      st_d.route = tick_route_i;
    end

    // ----------------------------------------------------------------
    // per-context state, pending and busy
    // ----------------------------------------------------------------
    for (int c = 0; c < NUM_CTX; c++)
    begin
      if (irq_done_i.valid && int'(irq_done_i.ctx) == c)
      begin
        st_d.busy[c] = 1'b0;
      end
      // a master write decides the state outright; an event in that cycle never undoes it
      if (cfg_hit[c])
      begin
        st_d.state[c] = ctx_wr_i.state;
        st_d.mode[c] = ctx_wr_i.mode;
        st_d.prio[c] = ctx_wr_i.prio;
      end
      // any event readies a not-ready context; halted ones stay put
      else if ((req[c] || wake[c]) && st_q.state[c] == ctx_sched_pkg::ST_NOT_READY)
      begin
        st_d.state[c] = ctx_sched_pkg::ST_READY;
      end
      // a wake tick never leaves a pending request behind
      if (req[c] && st_q.state[c] != ctx_sched_pkg::ST_HALTED)
      begin
        st_d.pend[c] = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // claim semaphores
    // ----------------------------------------------------------------
    // the master context owns no semaphore, so its bit is forced low
    st_d.claim[0] = 1'b0;
    for (int c = 1; c < NUM_CTX; c++)
    begin
      // a set and a clear in one cycle leave the claim held
      if (claim_set_i.valid && int'(claim_set_i.ctx) == c)
      begin
        st_d.claim[c] = 1'b1;
      end
      else if (claim_clr_i.valid && int'(claim_clr_i.ctx) == c)
      begin
        st_d.claim[c] = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // interrupt entry action for the selected context
    // ----------------------------------------------------------------
    st_d.sel.valid = best_found;
    st_d.sel.ctx = best_ctx;
    st_d.sel.action = ctx_sched_pkg::ACT_NONE;
    if (best_found && st_q.pend[best_ctx])
    begin
      case (st_q.mode[best_ctx])
        ctx_sched_pkg::MODE_STANDARD:
        begin
          // nesting allowed: each pending request stacks again
          st_d.sel.action = ctx_sched_pkg::ACT_STACK_VECTOR;
          st_d.pend[best_ctx] = req[best_ctx];
          st_d.busy[best_ctx] = 1'b1;
        end
        ctx_sched_pkg::MODE_FAST_VEC:
        begin
          // a request waits until the current handler signals done
          if (!st_q.busy[best_ctx])
          begin
            st_d.sel.action = ctx_sched_pkg::ACT_VECTOR_ONLY;
            st_d.pend[best_ctx] = req[best_ctx];
            st_d.busy[best_ctx] = 1'b1;
          end
        end
        ctx_sched_pkg::MODE_FAST_SINGLE:
        begin
          st_d.sel.action = ctx_sched_pkg::ACT_RESUME;
          st_d.pend[best_ctx] = req[best_ctx];
        end
        default:
        begin
          // encoding 11 is undefined; it behaves as standard mode
          st_d.sel.action = ctx_sched_pkg::ACT_STACK_VECTOR;
          st_d.pend[best_ctx] = req[best_ctx];
          st_d.busy[best_ctx] = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      // contexts come up halted, so nothing runs until the master writes a state
      st_q <= '0;
      st_q.state <= {NUM_CTX{ctx_sched_pkg::ST_RESET}};
      st_q.mode <= {NUM_CTX{ctx_sched_pkg::MODE_RESET}};
      st_q.prio <= {NUM_CTX{ctx_sched_pkg::PRIO_RESET}};
      st_q.prescale <= ctx_sched_pkg::PRESCALE_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  assign sched_o = st_q.sel;
  assign pending_o = st_q.pend;
  assign claim_o = st_q.claim;
  assign tick_o = st_q.tick;

endmodule // ctx_scheduler

// ==== pkg/ctx_sched_pkg.sv ====
// package: context scheduler and system timer types and constants
package ctx_sched_pkg;

  localparam int NUM_CTX = 5;
  localparam int NUM_TICK = 5;
  localparam int PRIO_W = 3;
  localparam int CTX_W = 3;
  localparam int PRESCALE_W = 16;
  localparam int RATE_W = 4;

  localparam logic [CTX_W-1:0] MASTER_CTX = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 16'h0000;
  localparam logic [RATE_W-1:0] RATE_MAX_SEL = 4'h9;

  // ----------------------------------------------------------------
  // execution state and interrupt response mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] ST_HALTED = 2'h0;
  localparam logic [1:0] ST_NOT_READY = 2'h1;
  localparam logic [1:0] ST_READY = 2'h2;
  localparam logic [1:0] ST_RESET = 2'h0;

  localparam logic [1:0] MODE_STANDARD = 2'h0;
  localparam logic [1:0] MODE_FAST_VEC = 2'h1;
  localparam logic [1:0] MODE_FAST_SINGLE = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // action the core takes when a context is entered for an interrupt
  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_STACK_VECTOR,
    ACT_VECTOR_ONLY,
    ACT_RESUME
  } irq_action_e;

  // configuration write from the core, tagged with the writing context
  typedef struct packed {
    logic valid;
    logic [CTX_W-1:0] src_ctx;
    logic [CTX_W-1:0] dst_ctx;
    logic [1:0] state;
    logic [1:0] mode;
    logic [PRIO_W-1:0] prio;
  } ctx_wr_s;

  typedef struct packed {
    logic valid;
    logic [CTX_W-1:0] src_ctx;
    logic enable;
    logic [RATE_W-1:0] rate_sel;
    logic [PRESCALE_W-1:0] prescale;
  } tmr_wr_s;

  // one-cycle event from the core or a peripheral
  typedef struct packed {
    logic valid;
    logic [CTX_W-1:0] ctx;
  } ctx_evt_s;

  // per-timer-output routing: wake mode or standard interrupt
  typedef struct packed {
    logic enable;
    logic wake_mode;
    logic [CTX_W-1:0] ctx;
  } tick_route_s;

  typedef struct packed {
    logic valid;
    logic [CTX_W-1:0] ctx;
    irq_action_e action;
  } sched_out_s;

endpackage

// ==== logic/sys_tick_gen.sv ====
// module: system timer producing five binary-divided periodic ticks
`timescale 1ns/1ps
module sys_tick_gen #(
  parameter int NUM_TICK = ctx_sched_pkg::NUM_TICK,
  parameter int PRESCALE_W = ctx_sched_pkg::PRESCALE_W
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic [ctx_sched_pkg::RATE_W-1:0] rate_sel_i,
  input wire logic [PRESCALE_W-1:0] prescale_i,
  output logic [NUM_TICK-1:0] tick_o
);

  typedef struct packed {
    logic [9:0] rate_cnt;
    logic [PRESCALE_W-1:0] pre_cnt;
    logic [NUM_TICK-2:0] div;
    logic [NUM_TICK-1:0] tick;
  } tick_st_s;

  tick_st_s st_q;
  tick_st_s st_d;
  logic [ctx_sched_pkg::RATE_W-1:0] sel_eff;
  logic [9:0] rate_top;
  logic rate_hit;
  logic base;

  // ----------------------------------------------------------------
  // bit-rate divider then prescaler; undefined selects clamp to 1024
  // ----------------------------------------------------------------
  always_comb
  begin
    sel_eff = (rate_sel_i > ctx_sched_pkg::RATE_MAX_SEL) ? ctx_sched_pkg::RATE_MAX_SEL : rate_sel_i;
    rate_top = 10'((11'h2 << sel_eff) - 11'h1);
    rate_hit = (st_q.rate_cnt >= rate_top);
    base = 1'b0;
    st_d = st_q;
    st_d.tick = '0;
    if (!enable_i)
    begin
      st_d.rate_cnt = '0;
      st_d.pre_cnt = '0;
      st_d.div = '0;
    end
    else if (rate_hit)
    begin
      st_d.rate_cnt = '0;
      // a prescale of zero is treated as one so the timer never stalls
      if (st_q.pre_cnt + 1'b1 >= prescale_i || prescale_i == '0)
      begin
        st_d.pre_cnt = '0;
        base = 1'b1;
      end
      else
      begin
        st_d.pre_cnt = st_q.pre_cnt + 1'b1;
      end
    end
    else
    begin
      st_d.rate_cnt = st_q.rate_cnt + 10'h1;
    end
    // output 0 at base rate, output k every 2^k base periods
    st_d.tick[0] = base;
    for (int k = 1; k < NUM_TICK; k++)
    begin
      // output k fires on the base event that completes 2^k of them
      st_d.tick[k] = base;
      for (int j = 0; j < k; j++)
      begin
        st_d.tick[k] = st_d.tick[k] && st_q.div[j];
      end
    end
    if (base)
    begin
      st_d.div = st_q.div + 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign tick_o = st_q.tick;

endmodule // sys_tick_gen

// ==== testbench/sched_checker.sv ====
// checker: port assertions for the context scheduler
`timescale 1ns/1ps
module sched_checker #(
  parameter int NUM_CTX = 5,
  parameter int NUM_TICK = 5
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire ctx_sched_pkg::ctx_wr_s ctx_wr_i,
  input wire ctx_sched_pkg::tmr_wr_s tmr_wr_i,
  input wire ctx_sched_pkg::ctx_evt_s irq_i,
  input wire ctx_sched_pkg::ctx_evt_s fault_i,
  input wire ctx_sched_pkg::ctx_evt_s trap_i,
  input wire ctx_sched_pkg::ctx_evt_s claim_set_i,
  input wire ctx_sched_pkg::ctx_evt_s claim_clr_i,
  input wire ctx_sched_pkg::sched_out_s sched_o,
  input wire logic [NUM_CTX-1:0] pending_o,
  input wire logic [NUM_CTX-1:0] claim_o,
  input wire logic [NUM_TICK-1:0] tick_o
);
  int gap_q [NUM_TICK];
  int per_q [NUM_TICK];
  int n_q [NUM_TICK];
  // a timer write restarts the tick count so partial first periods are never compared
  always_ff @(posedge mclk_i)
  begin
    for (int k = 0; k < NUM_TICK; k++)
    begin
      gap_q[k] <= tick_o[k] ? 1 : gap_q[k] + 1;
      per_q[k] <= tick_o[k] ? gap_q[k] : per_q[k];
      n_q[k] <= (!rst_n_i || tmr_wr_i.valid) ? 0 : n_q[k] + int'(tick_o[k] && n_q[k] < 3);
    end
  end
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_CLAIM_MASTER: assert property (claim_o[0] == 1'b0) else $error("master claim set");
  AST_CLAIM_SET: assert property (claim_set_i.valid && claim_set_i.ctx inside {[3'h1:3'h4]}
    |=> claim_o[$past(claim_set_i.ctx)]) else $error("claim not set");
  AST_CLAIM_CLR: assert property (claim_clr_i.valid && claim_clr_i.ctx != claim_set_i.ctx
    && claim_clr_i.ctx < 3'h5 |=> !claim_o[$past(claim_clr_i.ctx)]) else $error("claim not cleared");
  AST_MASTER_WINS: assert property (ctx_wr_i.valid && ctx_wr_i.src_ctx == 3'h0 && ctx_wr_i.dst_ctx == 3'h0
    && ctx_wr_i.state == 2'h2 ##1 !ctx_wr_i.valid |=> sched_o.valid && sched_o.ctx == 3'h0)
    else $error("master not selected");
  AST_CTX_RANGE: assert property (sched_o.valid |-> sched_o.ctx < 3'h5) else $error("context out of range");
  AST_ACT_SELECTED: assert property (sched_o.action != ctx_sched_pkg::ACT_NONE |-> sched_o.valid)
    else $error("action without selection");
  AST_PEND_MASTER: assert property ($rose(pending_o[0]) |-> |tick_o || $past(fault_i.valid || trap_i.valid
    || irq_i.valid && irq_i.ctx == 3'h0 || |tick_o)) else $error("master pending without cause");
  AST_TICK_HALF: assert property (tick_o[1] && n_q[1] > 0 && n_q[0] > 1 |-> gap_q[1] == 2 * per_q[0])
    else $error("tick one not half rate");
  cover property (sched_o.action == ctx_sched_pkg::ACT_VECTOR_ONLY);
  cover property (tick_o[4]);
  cover property ($rose(pending_o[0]));
endmodule // sched_checker

bind ctx_scheduler sched_checker #(.NUM_CTX(NUM_CTX), .NUM_TICK(NUM_TICK)) u_chk (.mclk_i, .rst_n_i, .ctx_wr_i,
  .tmr_wr_i, .irq_i, .fault_i, .trap_i, .claim_set_i, .claim_clr_i, .sched_o, .pending_o, .claim_o, .tick_o);

// ==== testbench/evt_source.sv ====
// partner: event sources that target contexts
`timescale 1ns/1ps
module evt_source (
  input wire logic mclk_i,
  output ctx_sched_pkg::ctx_evt_s irq_o,
  output ctx_sched_pkg::ctx_evt_s fault_o,
  output ctx_sched_pkg::ctx_evt_s trap_o,
  output ctx_sched_pkg::ctx_evt_s done_o
);
  initial {irq_o, fault_o, trap_o, done_o} = '0;
  // kind 0 irq, 1 fault, 2 trap, 3 handler done; lag makes a slow source
  task automatic raise(input int kind, input logic [2:0] ctx, input int lag);
    repeat (lag + 1) @(negedge mclk_i);
    drive(kind, {1'b1, ctx});
    @(negedge mclk_i);
    // a released context field shows junk, not the last value
    drive(kind, {1'b0, ~ctx});
  endtask
  task automatic drive(input int kind, input ctx_sched_pkg::ctx_evt_s ev);
    case (kind)
      0: irq_o = ev;
      1: fault_o = ev;
      2: trap_o = ev;
      default: done_o = ev;
    endcase
  endtask
endmodule // evt_source

// ==== testbench/hw_context_scheduler_timer_bench.sv ====
// bench: self-checking run of the context scheduler and system timer
`timescale 1ns/1ps
module hw_context_scheduler_timer_bench;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  ctx_sched_pkg::ctx_wr_s ctx_wr_i = '0;
  ctx_sched_pkg::tmr_wr_s tmr_wr_i = '0;
  ctx_sched_pkg::tick_route_s [4:0] tick_route_i = '0;
  logic route_wr_i = 1'b0;
  logic [2:0] route_src_i = 3'h0;
  ctx_sched_pkg::ctx_evt_s irq_i, fault_i, trap_i, irq_done_i;
  ctx_sched_pkg::ctx_evt_s claim_set_i = '0;
  ctx_sched_pkg::ctx_evt_s claim_clr_i = '0;
  ctx_sched_pkg::sched_out_s sched_o;
  logic [4:0] pending_o, claim_o, tick_o, cl;
  logic [1:0] st [5];
  logic [2:0] pr [5];
  int md, b, error_cnt = 0, checks_done = 0;
  ctx_scheduler u_dut (.mclk_i, .rst_n_i, .ctx_wr_i, .tmr_wr_i, .tick_route_i, .route_wr_i, .route_src_i,
    .irq_i, .fault_i, .trap_i, .irq_done_i, .claim_set_i, .claim_clr_i, .sched_o, .pending_o, .claim_o, .tick_o);
  evt_source u_src (.mclk_i, .irq_o(irq_i), .fault_o(fault_i), .trap_o(trap_i), .done_o(irq_done_i));
  initial forever #50 mclk_i = ~mclk_i;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic put(input logic [2:0] src, input int i);
    @(negedge mclk_i);
    ctx_wr_i = {1'b1, src, 3'(i), st[i], md[1:0], pr[i]};
    @(negedge mclk_i);
    ctx_wr_i.valid = 1'b0;
  endtask
  task automatic apply();
    for (int i = 0; i < 5; i++)
      put(3'h0, i);
    repeat (3) @(negedge mclk_i);
  endtask
  // expected pick: master first, then highest priority, lowest number on a tie
  function automatic logic [31:0] pick();
    logic [3:0] r;
    r = 4'h0;
    if (st[0] == 2'h2)
      return 32'h8;
    for (int i = 4; i > 0; i--)
      if (st[i] == 2'h2 && (!r[3] || pr[i] >= pr[r[2:0]]))
        r = {1'b1, 3'(i)};
    return 32'(r);
  endfunction
  function automatic logic [31:0] sel();
    return 32'({sched_o.valid, sched_o.valid ? sched_o.ctx : 3'h0});
  endfunction
  task automatic wact(input logic [1:0] exp);
    for (int n = 0; n < 6 && sched_o.action == ctx_sched_pkg::ACT_NONE; n++)
      @(negedge mclk_i);
    check("action", 32'(sched_o.action), 32'(exp));
    @(negedge mclk_i);
  endtask
  task automatic period(input int k, input int exp);
    int n;
    for (n = 0; n < 1000 && tick_o[k] !== 1'b1; n++)
      @(negedge mclk_i);
    for (n = 1; n < 1000; n++)
    begin
      @(negedge mclk_i);
      if (tick_o[k] === 1'b1)
        break;
    end
    check("tick period", 32'(n), 32'(exp));
  endtask
  initial
  begin
    ctx_sched_pkg::irq_action_e act [3];
    act = '{ctx_sched_pkg::ACT_STACK_VECTOR, ctx_sched_pkg::ACT_VECTOR_ONLY, ctx_sched_pkg::ACT_RESUME};
    b = $urandom(30);
    cl = 5'h0;
    md = 0;
    repeat (12) @(negedge mclk_i);
    check("reset outputs", 32'({sched_o, pending_o, claim_o, tick_o}), 32'h0);
    rst_n_i = 1'b1;
    st = '{default: 2'h2};
    pr = '{default: 3'h3};
    put(3'h2, 3);
    repeat (3) @(negedge mclk_i);
    check("refused write", sel(), 32'h0);
    for (int t = 0; t < 24; t++)
    begin
      for (int i = 0; i < 5; i++)
      begin
        st[i] = t == 0 ? 2'h2 : 2'($urandom % 3);
        pr[i] = t == 0 ? 3'h3 : 3'($urandom);
      end
      st[0] = t == 0 ? 2'h0 : st[0];
      apply();
      check("selection", sel(), pick());
      claim_set_i = {1'b1, 3'($urandom % 5)};
      claim_clr_i = {1'b1, 3'($urandom % 5)};
      cl[claim_clr_i.ctx] = 1'b0;
      cl[claim_set_i.ctx] = claim_set_i.ctx != 3'h0;
      @(negedge mclk_i);
      claim_set_i.valid = 1'b0;
      claim_clr_i.valid = 1'b0;
      @(negedge mclk_i);
      check("claims", 32'(claim_o), 32'(cl));
    end
    st = '{default: 2'h0};
    st[2] = 2'h2;
    for (int m = 0; m < 3; m++)
    begin
      md = m;
      apply();
      u_src.raise(0, 3'h2, m);
      wact(act[m]);
      u_src.raise(0, 3'h2, 0);
      wact(m == 1 ? ctx_sched_pkg::ACT_NONE : act[m]);
      check("pending", 32'(pending_o), m == 1 ? 32'h4 : 32'h0);
      u_src.raise(3, 3'h2, 0);
      wact(m == 1 ? act[1] : ctx_sched_pkg::ACT_NONE);
    end
    md = 0;
    for (int k = 0; k < 3; k++)
    begin
      st = '{default: 2'h0};
      st[k == 0 ? 3 : 0] = 2'h1;
      apply();
      check("not ready idle", sel(), 32'h0);
      u_src.raise(k, 3'h3, 1);
      repeat (3) @(negedge mclk_i);
      check("woken context", sel(), k == 0 ? 32'hb : 32'h8);
    end
    st = '{default: 2'h0};
    st[4] = 2'h1;
    apply();
    tick_route_i[0] = '{1'b1, 1'b1, 3'h4};
    route_wr_i = 1'b1;
    @(negedge mclk_i);
    route_wr_i = 1'b0;
    tmr_wr_i = {1'b1, 3'h0, 1'b1, 4'($urandom % 3), 16'($urandom % 3 + 1)};
    @(negedge mclk_i);
    tmr_wr_i.valid = 1'b0;
    b = (2 << tmr_wr_i.rate_sel) * tmr_wr_i.prescale;
    for (int k = 0; k < 5; k++)
      period(k, b << k);
    check("wake", sel(), 32'hc);
    complete_run();
  end
endmodule // hw_context_scheduler_timer_bench
